// ==== rtl/bus_fault_pkg.sv ====
package bus_fault_pkg;
    // Bit positions inside the configurable fault status word
    localparam int unsigned INSTRUCTION_BUS_ERROR_FLAG_BIT = 8;
    localparam int unsigned PRECISE_BIT = 9;
    localparam int unsigned IMPRECISE_BIT = 10;
    localparam int unsigned UNSTACK_BIT = 11;
    localparam int unsigned ADDR_VALID_BIT = 15;
    // The status byte carries bits 15:8 of the word
    localparam int unsigned STATUS_LSB = 8;
    localparam int unsigned STATUS_W = 8;
    // Flag slots in the flag cell array
    localparam int unsigned FLAG_COUNT = 5;
    localparam int unsigned SLOT_INSTRUCTION_BUS_ERROR_FLAG = 0;
    localparam int unsigned SLOT_PRECISE = 1;
    localparam int unsigned SLOT_IMPRECISE = 2;
    localparam int unsigned SLOT_UNSTACK = 3;
    localparam int unsigned SLOT_VALID = 4;
    // Values after reset
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [1:0] RST_SYNC_RESET = 2'h0;
endpackage

// ==== rtl/bus_fault_status.sv ====
`timescale 1ns/1ps
module bus_fault_status
    import bus_fault_pkg::*;
#(
    parameter int unsigned ADDR_W = 32,
    parameter int unsigned PRIO_W = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic unstackFault,
    input wire logic impreciseErr,
    input wire logic preciseErr,
    input wire logic [ADDR_W-1:0] preciseAddr,
    input wire logic ibusPrefetchErr,
    input wire logic ibusIssue,
    input wire logic ibusFlush,
    input wire logic otherFaultAddr,
    input wire logic [PRIO_W-1:0] execPrio,
    input wire logic [PRIO_W-1:0] busFaultPrio,
    input wire logic swClrWr,
    input wire logic [STATUS_W-1:0] swClrData,
    output logic [STATUS_W-1:0] statusByte,
    output logic [ADDR_W-1:0] bus_fault_address_register_r,
    output logic impPending_r,
    output logic chainToHandler_r,
    output logic holdReturnStack_r,
    output logic contextSave_r
);
    logic [1:0] rstSync_r;
    logic rstn;
    logic higherNow;
    logic impTake;
    logic ibusSetNow;
    logic ibusFetchBad_r;
    logic ibusFetchBad_nxt;
    logic impPending_nxt;
    logic saveNow;
    logic [FLAG_COUNT-1:0] setVec;
    logic [FLAG_COUNT-1:0] clrVec;
    logic [FLAG_COUNT-1:0] qVec;

    // Reset released through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstSync_r <= RST_SYNC_RESET;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstn = rstSync_r[1];

    // Lower number means higher priority, as usual for exception levels
    assign higherNow = execPrio < busFaultPrio;
    assign impTake = impPending_r & ~higherNow;
    assign impPending_nxt = impreciseErr | (impPending_r & ~impTake);
    assign ibusSetNow = ibusIssue & ibusFetchBad_r;
    // Prefetch error is remembered; a flush discards the fetched word
    assign ibusFetchBad_nxt = ibusPrefetchErr | (ibusFetchBad_r & ~ibusFlush & ~ibusIssue);
    // Unstacking fault chains without a save of its own
    assign saveNow = preciseErr | ibusSetNow | impTake;

    // Flag set events, one per slot
    assign setVec[SLOT_INSTRUCTION_BUS_ERROR_FLAG] = ibusSetNow;
    assign setVec[SLOT_PRECISE] = preciseErr;
    assign setVec[SLOT_IMPRECISE] = impreciseErr;
    assign setVec[SLOT_UNSTACK] = unstackFault;
    assign setVec[SLOT_VALID] = preciseErr;

    // Write-one-to-clear decode from the status byte image
    assign clrVec[SLOT_INSTRUCTION_BUS_ERROR_FLAG] = swClrWr & swClrData[INSTRUCTION_BUS_ERROR_FLAG_BIT-STATUS_LSB];
    assign clrVec[SLOT_PRECISE] = swClrWr & swClrData[PRECISE_BIT-STATUS_LSB];
    assign clrVec[SLOT_IMPRECISE] = swClrWr & swClrData[IMPRECISE_BIT-STATUS_LSB];
    assign clrVec[SLOT_UNSTACK] = swClrWr & swClrData[UNSTACK_BIT-STATUS_LSB];
    // Address valid also drops when another fault kind owns the address
    assign clrVec[SLOT_VALID] = (swClrWr & swClrData[ADDR_VALID_BIT-STATUS_LSB])
        | otherFaultAddr;

    // Independent sticky cells, so one set never touches another
    genvar g;
    generate
        for (g = 0; g < FLAG_COUNT; g++) begin : gFlag
            flag_if fi ();
            assign fi.setEv = setVec[g];
            assign fi.clrEv = clrVec[g];
            assign qVec[g] = fi.q;
            flag_w1c uCell (
                .clk(mclk),
                .rstn(rstn),
                .fl(fi)
            );
        end
    endgenerate

    // Status byte image; reserved bits and the stacking bit read zero
    assign statusByte = {qVec[SLOT_VALID], 3'h0, qVec[SLOT_UNSTACK],
        qVec[SLOT_IMPRECISE], qVec[SLOT_PRECISE], qVec[SLOT_INSTRUCTION_BUS_ERROR_FLAG]};

    // Fault address loads only from a precise error
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bus_fault_address_register_r <= ADDR_RESET[ADDR_W-1:0];
        end else if (preciseErr) begin
            bus_fault_address_register_r <= preciseAddr;
        end
    end

    // Pending imprecise fault and instruction fetch tracking
    // Only one imprecise fault is held; a second one while pending merges into it
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            impPending_r <= 1'b0;
            ibusFetchBad_r <= 1'b0;
        end else begin
            impPending_r <= impPending_nxt;
            ibusFetchBad_r <= ibusFetchBad_nxt;
        end
    end

    // Handler entry controls; chaining keeps the old frame in place
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chainToHandler_r <= 1'b0;
            holdReturnStack_r <= 1'b0;
            contextSave_r <= 1'b0;
        end else begin
            chainToHandler_r <= unstackFault;
            holdReturnStack_r <= unstackFault;
            contextSave_r <= saveNow;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence sImpThenPrecise;
        (impPending_r && qVec[SLOT_IMPRECISE]) ##0 (preciseErr && !swClrWr);
    endsequence

    sequence sFetchThenIssue;
        ibusPrefetchErr ##1 ibusIssue;
    endsequence

    sequence sHeldHigh;
        impPending_r && higherNow && !preciseErr && !ibusSetNow;
    endsequence

    AST_UNSTACK_SETS: assert property (
        unstackFault |=> statusByte[UNSTACK_BIT-STATUS_LSB])
        else $error("unstack flag not set");
    AST_UNSTACK_CHAIN: assert property (
        unstackFault |=> chainToHandler_r && holdReturnStack_r)
        else $error("unstack fault not chained");
    AST_UNSTACK_NOSAVE: assert property (
        (unstackFault && !saveNow) |=> !contextSave_r && $stable(bus_fault_address_register_r))
        else $error("unstack fault saved context or loaded address");
    AST_IMPRECISE_DATA_ERROR_FLAG_NOADDR: assert property (
        (impreciseErr && !preciseErr) |=> statusByte[IMPRECISE_BIT-STATUS_LSB]
            && $stable(bus_fault_address_register_r))
        else $error("imprecise error wrong");
    AST_IMPRECISE_DATA_ERROR_FLAG_WAIT: assert property (
        sHeldHigh |=> !contextSave_r && impPending_r)
        else $error("imprecise fault taken under higher priority");
    AST_BOTH_FLAGS: assert property (
        sImpThenPrecise |=> statusByte[IMPRECISE_BIT-STATUS_LSB]
            && statusByte[PRECISE_BIT-STATUS_LSB])
        else $error("imprecise and precise not both set");
    AST_PRECISE_ADDR: assert property (
        preciseErr |=> bus_fault_address_register_r == $past(preciseAddr)
            && statusByte[PRECISE_BIT-STATUS_LSB] && contextSave_r)
        else $error("precise error address not loaded");
    AST_INSTRUCTION_BUS_ERROR_FLAG_AT_ISSUE: assert property (
        (!ibusSetNow && !statusByte[INSTRUCTION_BUS_ERROR_FLAG_BIT-STATUS_LSB] && !clrVec[SLOT_INSTRUCTION_BUS_ERROR_FLAG])
            |=> !statusByte[INSTRUCTION_BUS_ERROR_FLAG_BIT-STATUS_LSB])
        else $error("instruction bus flag set without issue");
    AST_W1C_ZERO_KEEPS: assert property (
        (swClrWr && swClrData == 8'h00 && !otherFaultAddr) |=> $stable(qVec) || |$past(setVec))
        else $error("writing zero changed a flag");
    AST_W1C_CLEARS: assert property (
        (clrVec[SLOT_UNSTACK] && !unstackFault) |=> !statusByte[UNSTACK_BIT-STATUS_LSB])
        else $error("write one did not clear");
    AST_VALID_SET: assert property (
        preciseErr |=> statusByte[ADDR_VALID_BIT-STATUS_LSB] [*1]
            ##0 impPending_r == $past(impPending_nxt))
        else $error("address valid not set");
    AST_ACCUMULATE: assert property (
        (qVec[SLOT_IMPRECISE] && !clrVec[SLOT_IMPRECISE]) |=> qVec[SLOT_IMPRECISE])
        else $error("flag lost while others set");

    // Pulse length, pending activation, address ownership and flag independence, seen from ports and internal signals
    AST_CHAIN_PULSE: assert property (
        !unstackFault |=> !chainToHandler_r && !holdReturnStack_r)
        else $error("chain pulse outlived its fault");
    AST_IMPRECISE_DATA_ERROR_FLAG_TAKE: assert property (
        (impPending_r && !higherNow) |=> contextSave_r && impPending_r == $past(impreciseErr))
        else $error("pending imprecise fault not activated");
    AST_INSTRUCTION_BUS_ERROR_FLAG_NOADDR: assert property (
        (ibusSetNow && !preciseErr) |=> $stable(bus_fault_address_register_r) && statusByte[INSTRUCTION_BUS_ERROR_FLAG_BIT-STATUS_LSB])
        else $error("instruction bus error touched the address");
    AST_INSTRUCTION_BUS_ERROR_FLAG_AFTER_FETCH: assert property (
        sFetchThenIssue |=> statusByte[INSTRUCTION_BUS_ERROR_FLAG_BIT-STATUS_LSB])
        else $error("issued faulting instruction left flag clear");
    AST_VALID_DROPS: assert property (
        (otherFaultAddr && !preciseErr) |=> !statusByte[ADDR_VALID_BIT-STATUS_LSB])
        else $error("address valid kept after another fault");
    AST_VALID_KEEPS: assert property (
        (statusByte[ADDR_VALID_BIT-STATUS_LSB] && !otherFaultAddr && !swClrWr)
            |=> statusByte[ADDR_VALID_BIT-STATUS_LSB])
        else $error("address valid lost without a clear");
    AST_SET_KEEPS_OTHERS: assert property (
        (preciseErr && qVec[SLOT_UNSTACK] && !clrVec[SLOT_UNSTACK]) |=> qVec[SLOT_UNSTACK])
        else $error("precise error disturbed the unstack flag");
endmodule

// ==== rtl/flag_if.sv ====
`timescale 1ns/1ps
// One sticky flag: a set event, a clear event and the held level
interface flag_if;
    logic setEv;
    logic clrEv;
    logic q;
    modport owner (input setEv, input clrEv, output q);
    modport user (output setEv, output clrEv, input q);
endinterface

// ==== rtl/flag_w1c.sv ====
`timescale 1ns/1ps
module flag_w1c
    import bus_fault_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    flag_if.owner fl
);
    logic q_r;
    logic q_nxt;

    // Set wins over a clear landing in the same cycle
    assign q_nxt = fl.setEv | (q_r & ~fl.clrEv);
    assign fl.q = q_r;

    // Sticky until cleared
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q_r <= FLAG_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
    import bus_fault_pkg::*;
();
    logic mclk, resetn, unstackFault, impreciseErr, preciseErr, ibusPrefetchErr, ibusIssue;
    logic ibusFlush, otherFaultAddr, swClrWr;
    logic [31:0] preciseAddr;
    logic [7:0] execPrio, busFaultPrio, swClrData;
    logic [STATUS_W-1:0] statusByte;
    logic [31:0] bus_fault_address_register_r;
    logic impPending_r, chainToHandler_r, holdReturnStack_r, contextSave_r;
    int failures = 0;
    int cmpCount = 0;
    // Event bits, in the order that fire drives them
    localparam logic [7:0] NO_EV = 8'h00;
    localparam logic [7:0] UNSTACK_EV = 8'h80;
    localparam logic [7:0] IMP_EV = 8'h40;
    localparam logic [7:0] PRE_EV = 8'h20;
    localparam logic [7:0] FETCH_EV = 8'h10;
    localparam logic [7:0] ISSUE_EV = 8'h08;
    localparam logic [7:0] FLUSH_EV = 8'h04;
    localparam logic [7:0] OTHER_EV = 8'h02;
    localparam logic [7:0] CLR_EV = 8'h01;

    bus_fault_status dut (.mclk(mclk), .resetn(resetn), .unstackFault(unstackFault),
        .impreciseErr(impreciseErr), .preciseErr(preciseErr), .preciseAddr(preciseAddr),
        .ibusPrefetchErr(ibusPrefetchErr), .ibusIssue(ibusIssue), .ibusFlush(ibusFlush),
        .otherFaultAddr(otherFaultAddr), .execPrio(execPrio), .busFaultPrio(busFaultPrio),
        .swClrWr(swClrWr), .swClrData(swClrData), .statusByte(statusByte),
        .bus_fault_address_register_r(bus_fault_address_register_r), .impPending_r(impPending_r),
        .chainToHandler_r(chainToHandler_r), .holdReturnStack_r(holdReturnStack_r),
        .contextSave_r(contextSave_r));

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic stop_test;
        if (failures == 0 && cmpCount > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Inputs always move 1 ns after the rising edge
    task automatic step;
        @(posedge mclk);
        #1;
    endtask

    // One cycle of events; the next call replaces them, so each input
    // is written once per time step and back-to-back strobes stay high
    task automatic fire(input logic [7:0] ev);
        {unstackFault, impreciseErr, preciseErr, ibusPrefetchErr} = ev[7:4];
        {ibusIssue, ibusFlush, otherFaultAddr, swClrWr} = ev[3:0];
        step;
    endtask

    task automatic clear_all;
        swClrData = 8'hff;
        fire(CLR_EV);
        chk("status cleared", 32'(statusByte), 32'h0);
    endtask

    task automatic t_precise;
        preciseAddr = 32'hdead_beec;
        fire(PRE_EV);
        chk("precise status", 32'(statusByte), 32'h82);
        chk("fault addr", bus_fault_address_register_r, 32'hdead_beec);
        chk("precise save", 32'(contextSave_r), 32'h1);
        swClrData = 8'h00;
        fire(CLR_EV);
        chk("zero write", 32'(statusByte), 32'h82);
        chk("save pulse", 32'(contextSave_r), 32'h0);
        swClrData = 8'h02;
        fire(CLR_EV);
        chk("bit9 cleared", 32'(statusByte), 32'h80);
        fire(OTHER_EV);
        chk("valid dropped", 32'(statusByte), 32'h0);
        chk("addr after drop", bus_fault_address_register_r, 32'hdead_beec);
    endtask

    task automatic t_unstack;
        fire(UNSTACK_EV);
        chk("unstack status", 32'(statusByte), 32'h08);
        chk("chain", 32'({chainToHandler_r, holdReturnStack_r}), 32'h3);
        chk("no save", 32'(contextSave_r), 32'h0);
        chk("addr kept", bus_fault_address_register_r, 32'hdead_beec);
        preciseAddr = 32'h0000_1230;
        swClrData = 8'h82;
        fire(PRE_EV | CLR_EV);
        chk("set wins", 32'(statusByte), 32'h8a);
        chk("chain pulse", 32'({chainToHandler_r, holdReturnStack_r}), 32'h0);
        clear_all;
    endtask

    task automatic t_imprecise;
        execPrio = 8'h01;
        fire(IMP_EV);
        chk("imprecise status", 32'(statusByte), 32'h04);
        chk("addr untouched", bus_fault_address_register_r, 32'h0000_1230);
        repeat (3) fire(NO_EV);
        chk("still pending", 32'({impPending_r, contextSave_r}), 32'h2);
        fire(PRE_EV);
        chk("both flags", 32'(statusByte), 32'h86);
        fire(NO_EV);
        chk("held after precise", 32'({impPending_r, contextSave_r}), 32'h2);
        execPrio = 8'h05;
        fire(NO_EV);
        chk("activated", 32'({impPending_r, contextSave_r}), 32'h1);
        clear_all;
    endtask

    task automatic t_instruction_bus_error_flag;
        fire(FETCH_EV | ISSUE_EV);
        chk("same cycle issue", 32'(statusByte), 32'h0);
        fire(FLUSH_EV);
        fire(FETCH_EV);
        fire(FLUSH_EV);
        fire(ISSUE_EV);
        chk("no instruction_bus_error_flag flag", 32'(statusByte), 32'h0);
        fire(FETCH_EV);
        chk("prefetch only", 32'(statusByte), 32'h0);
        fire(ISSUE_EV);
        chk("instruction_bus_error_flag status", 32'(statusByte), 32'h01);
        chk("instruction_bus_error_flag addr", bus_fault_address_register_r, 32'h0000_1230);
        clear_all;
    endtask

    // Mid-run reset must wipe set flags, pulses and the address
    task automatic t_reset;
        preciseAddr = 32'h0000_4560;
        fire(UNSTACK_EV | PRE_EV);
        chk("before reset", 32'(statusByte), 32'h8a);
        resetn = 1'b0;
        fire(NO_EV);
        chk("reset flags", 32'(statusByte), 32'h0);
        chk("reset pulses", 32'({impPending_r, chainToHandler_r, holdReturnStack_r,
            contextSave_r}), 32'h0);
        chk("reset addr mid", bus_fault_address_register_r, 32'h0);
        repeat (2) step;
        resetn = 1'b1;
        repeat (4) step;
        chk("after release", 32'(statusByte), 32'h0);
    endtask

    // Whole run is well under 1000 cycles
    initial begin
        #20000;
        failures++;
        stop_test;
    end

    // Main sequence
    initial begin
        resetn = 1'b0;
        {unstackFault, impreciseErr, preciseErr, ibusPrefetchErr} = 4'h0;
        {ibusIssue, ibusFlush, otherFaultAddr, swClrWr} = 4'h0;
        preciseAddr = 32'h0;
        execPrio = 8'h00;
        busFaultPrio = 8'h05;
        swClrData = 8'h00;
        repeat (12) @(posedge mclk);
        #1;
        resetn = 1'b1;
        repeat (4) step;
        chk("reset status", 32'(statusByte), 32'h0);
        chk("reset addr", bus_fault_address_register_r, 32'h0);
        t_precise;
        t_unstack;
        t_imprecise;
        t_instruction_bus_error_flag;
        t_reset;
        stop_test;
    end
endmodule
